// *** dcc_pkg.sv ***
// Shared constants of the two-channel cycle-steal transfer controller.
// Assumes a 20-bit memory address space and 32-bit register words.
package dcc_pkg;
	localparam int ADDR_W = 20;
	localparam int CNT_W = 16;
	// Register byte offsets; channel one sits one stride above channel zero
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SRC = 8'h04;
	localparam logic [7:0] OFS_DST = 8'h08;
	localparam logic [7:0] OFS_RELOAD = 8'h0c;
	localparam logic [7:0] OFS_COUNT = 8'h10;
	localparam logic [7:0] CH_STRIDE = 8'h20;
	localparam logic [7:0] OFS_CFG = 8'h40;
	// Control register fields
	localparam int CB_EN = 0;
	localparam int CB_UNIT8 = 1;
	localparam int CB_SINC = 2;
	localparam int CB_DINC = 3;
	localparam int CB_SINGLE = 4;
	localparam int CB_REQ = 5;
	localparam int CB_SWTRIG = 6;
	localparam int CB_SEL_LO = 8;
	localparam int SEL_W = 4;
	// Configuration register fields, then register reset values
	localparam int GB_INT_WAIT = 0;
	localparam int GB_EXT_WAIT = 1;
	localparam int GB_EXT_MUX = 2;
	localparam logic [2:0] CFG_RESET = 3'h0;
	localparam logic [ADDR_W-1:0] PTR_RESET = 20'h00000;
	localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
	// Request source selection codes; codes from SEL_PERIPH0 pick a peripheral
	localparam logic [SEL_W-1:0] SEL_SOFT = 4'h0;
	localparam logic [SEL_W-1:0] SEL_EXT_FALL = 4'h1;
	localparam logic [SEL_W-1:0] SEL_EXT_BOTH = 4'h2;
	localparam logic [SEL_W-1:0] SEL_PERIPH0 = 4'h4;
	// Address map areas
	localparam logic [ADDR_W-1:0] SFA_TOP = 20'h00400;
	localparam logic [ADDR_W-1:0] INT_TOP = 20'h04000;
	// Clocks per bus cycle, then register bus response codes
	localparam logic [1:0] J_FAST = 2'h1;
	localparam logic [1:0] J_WAIT = 2'h2;
	localparam logic [1:0] J_MUX = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} dcc_state_t;
endpackage

// *** dcc_dma.sv ***
// Two-channel cycle-steal transfer controller with AXI4-Lite registers.
// Assumes the memory bus finishes each cycle in the clocks given by its area,
// and that the CPU pulses cpu_access_done once per own bus access.
// Overview of operation
// - 16-bit odd start on 16-bit bus: extra cycles
// - Byte bus in expansion: two reads, two writes
// - Internal areas use width of bus select pin in expansion mode only
// - Special area or waited area: one clock longer
// - Unit cycles are reads times j plus writes times k
// - Byte units one each; word units per address, bus
// - Any even/odd address mix is accepted
// - Enable write loads incrementing pointer at first transfer
// - First transfer loads counter from reload register
// - Rewriting enable restarts channel from initial state
// - Request flag set regardless of enable
// - Request flag clears just before transfer starts
// - Software writes zero to clear, one ignored
// - Peripheral requests set flag with its interrupt
// - Selected external pin acts as transfer request
// - External requests set flag on chosen edge
// - Simultaneous requests set all flags together
// - Channel zero wins when both request together
// - One CPU access between consecutive transfers
// - Each unit is source read then destination write
// - Counter underflow interrupts; single mode then stops
// - Source and destination never both increment
// - Fixed pointers writable only while disabled
`default_nettype none
`timescale 1ns/1ns
module dcc_dma #(
	parameter int NUM_PERIPH = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic expansion_mode,
	input wire logic bus_width_select,
	input wire logic [1:0] external_interrupt_pin,
	input wire logic [NUM_PERIPH-1:0] periph_irq,
	input wire logic cpu_access_done,
	output logic bus_hold,
	output logic mem_valid,
	output logic mem_write,
	output logic mem_byte,
	output logic [dcc_pkg::ADDR_W-1:0] mem_addr,
	output logic [15:0] mem_wdata,
	input wire logic [15:0] mem_rdata,
	output logic [1:0] dma_irq
);
	localparam int AW = dcc_pkg::ADDR_W;
	localparam int CW = dcc_pkg::CNT_W;

	logic [1:0] en_q, unit8_q, sinc_q, dinc_q, single_q, req_q, first_q;
	logic [dcc_pkg::SEL_W-1:0] sel_q [2];
	logic [AW-1:0] src_q [2];
	logic [AW-1:0] dst_q [2];
	logic [AW-1:0] wptr_q [2];
	logic [CW-1:0] rld_q [2];
	logic [CW-1:0] cnt_q [2];
	logic [2:0] cfg_q;
	logic [1:0] pin_prev_q;
	logic [1:0] irq_q;

	// Bus slave state
	logic aw_got_q, w_got_q, bvalid_q, rvalid_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic wr_do;
	logic [31:0] wmask;

	// Engine state
	dcc_pkg::dcc_state_t state_q;
	logic ch_q;
	logic need_cpu_q;
	logic [AW-1:0] addr_q, dst_a_q;
	logic part_q, rd_two_q, wr_two_q;
	logic [1:0] clk_q, rd_len_q, wr_len_q;
	logic [15:0] data_q;
	logic go, go_ch, done;
	logic [AW-1:0] go_src, go_dst;
	logic [1:0] ev;
	logic bus8;
	logic [7:0] ch_base [2];

	function automatic logic [1:0] cyc_len(input logic [AW-1:0] a, input logic [2:0] cfg);
		logic [1:0] r;
		r = dcc_pkg::J_FAST;
		if (a < dcc_pkg::SFA_TOP) begin
			r = dcc_pkg::J_WAIT;
		end else if (a < dcc_pkg::INT_TOP) begin
			r = cfg[dcc_pkg::GB_INT_WAIT] ? dcc_pkg::J_WAIT : dcc_pkg::J_FAST;
		end else if (cfg[dcc_pkg::GB_EXT_MUX]) begin
			r = dcc_pkg::J_MUX;
		end else begin
			r = cfg[dcc_pkg::GB_EXT_WAIT] ? dcc_pkg::J_WAIT : dcc_pkg::J_FAST;
		end
		return r;
	endfunction

	// Byte bus only exists in expansion mode; internal areas follow it too
	assign bus8 = expansion_mode & bus_width_select;
	assign ch_base[0] = 8'h00;
	assign ch_base[1] = dcc_pkg::CH_STRIDE;

	function automatic logic two_parts(input logic [AW-1:0] a, input logic u8, input logic b8);
		return !u8 && (b8 || a[0]);
	endfunction

	// Request events, sampled in the same clock for both channels
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_prev_q <= 2'h3;
		end else begin
			pin_prev_q <= external_interrupt_pin;
		end
	end

	always_comb begin
		for (int c = 0; c < 2; c++) begin
			ev[c] = 1'b0;
			if (sel_q[c] == dcc_pkg::SEL_EXT_FALL) begin
				ev[c] = pin_prev_q[c] & ~external_interrupt_pin[c];
			end else if (sel_q[c] == dcc_pkg::SEL_EXT_BOTH) begin
				ev[c] = pin_prev_q[c] ^ external_interrupt_pin[c];
			end else if (sel_q[c] >= dcc_pkg::SEL_PERIPH0) begin
				for (int p = 0; p < NUM_PERIPH; p++) begin
					if (32'(sel_q[c] - dcc_pkg::SEL_PERIPH0) == p) begin
						ev[c] = periph_irq[p];
					end
				end
			end
			if (wr_do && awaddr_q == (dcc_pkg::OFS_CTRL + (c == 1 ? dcc_pkg::CH_STRIDE : 8'h00))
				&& wstrb_q[0] && wdata_q[dcc_pkg::CB_SWTRIG]) begin
				ev[c] = 1'b1;
			end
		end
	end

	// AXI4-Lite write channel
	assign s_axi_awready = !aw_got_q;
	assign s_axi_wready = !w_got_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign wr_do = aw_got_q && w_got_q && !bvalid_q;
	assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= dcc_pkg::RESP_OKAY;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && !aw_got_q) begin
				aw_got_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_got_q) begin
				w_got_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_do) begin
				bvalid_q <= 1'b1;
				bresp_q <= (awaddr_q[7:6] == 2'h0 && awaddr_q[4:0] <= dcc_pkg::OFS_RELOAD[4:0]
					&& awaddr_q[1:0] == 2'h0) || awaddr_q == dcc_pkg::OFS_CFG
					? dcc_pkg::RESP_OKAY : dcc_pkg::RESP_SLVERR;
			end
			if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
			end
		end
	end

	// AXI4-Lite read channel
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= dcc_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && !rvalid_q) begin
			rvalid_q <= 1'b1;
			rdata_q <= 32'h00000000;
			rresp_q <= dcc_pkg::RESP_OKAY;
			if (s_axi_araddr == dcc_pkg::OFS_CFG) begin
				rdata_q <= {29'h0, cfg_q};
			end else if (s_axi_araddr[7:6] == 2'h0 && s_axi_araddr[1:0] == 2'h0
				&& s_axi_araddr[4:0] <= dcc_pkg::OFS_COUNT[4:0]) begin
				for (int c = 0; c < 2; c++) begin
					if (32'(s_axi_araddr[5]) == c) begin
						unique case (s_axi_araddr[4:0])
							dcc_pkg::OFS_CTRL[4:0]: rdata_q <= {20'h0, sel_q[c], 1'b0, 1'b0, req_q[c],
								single_q[c], dinc_q[c], sinc_q[c], unit8_q[c], en_q[c]};
							// Incrementing pointer reads back the live address while enabled
							dcc_pkg::OFS_SRC[4:0]: rdata_q <= {12'h0, (en_q[c] && sinc_q[c] && !first_q[c])
								? wptr_q[c] : src_q[c]};
							dcc_pkg::OFS_DST[4:0]: rdata_q <= {12'h0, (en_q[c] && dinc_q[c] && !first_q[c])
								? wptr_q[c] : dst_q[c]};
							dcc_pkg::OFS_RELOAD[4:0]: rdata_q <= {16'h0, rld_q[c]};
							default: rdata_q <= {16'h0, cnt_q[c]};
						endcase
					end
				end
			end else begin
				rresp_q <= dcc_pkg::RESP_SLVERR;
			end
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_q <= dcc_pkg::CFG_RESET;
		end else if (wr_do && awaddr_q == dcc_pkg::OFS_CFG && wstrb_q[0]) begin
			cfg_q <= wdata_q[2:0];
		end
	end

	// Channel control, flags, pointers and counters
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			en_q <= 2'h0;
			unit8_q <= 2'h0;
			sinc_q <= 2'h0;
			dinc_q <= 2'h0;
			single_q <= 2'h0;
			req_q <= 2'h0;
			first_q <= 2'h0;
			irq_q <= 2'h0;
			for (int c = 0; c < 2; c++) begin
				sel_q[c] <= dcc_pkg::SEL_SOFT;
				src_q[c] <= dcc_pkg::PTR_RESET;
				dst_q[c] <= dcc_pkg::PTR_RESET;
				wptr_q[c] <= dcc_pkg::PTR_RESET;
				rld_q[c] <= dcc_pkg::CNT_RESET;
				cnt_q[c] <= dcc_pkg::CNT_RESET;
			end
		end else begin
			irq_q <= 2'h0;
			for (int c = 0; c < 2; c++) begin
				// Transfer start clears, then software clear, then a new event wins
				if (go && 32'(go_ch) == c) begin
					req_q[c] <= 1'b0;
					first_q[c] <= 1'b0;
					if (first_q[c]) begin
						wptr_q[c] <= sinc_q[c] ? src_q[c] : dst_q[c];
						cnt_q[c] <= rld_q[c];
					end
				end
				if (done && 32'(ch_q) == c) begin
					if (sinc_q[c] || dinc_q[c]) begin
						wptr_q[c] <= wptr_q[c] + (unit8_q[c] ? 20'h00001 : 20'h00002);
					end
					if (cnt_q[c] == dcc_pkg::CNT_RESET) begin
						irq_q[c] <= 1'b1;
						if (single_q[c]) begin
							en_q[c] <= 1'b0;
						end else begin
							first_q[c] <= 1'b1;
						end
					end else begin
						cnt_q[c] <= cnt_q[c] - 16'h0001;
					end
				end
				if (wr_do && awaddr_q == ch_base[c] + dcc_pkg::OFS_CTRL) begin
					if (wstrb_q[0]) begin
						en_q[c] <= wdata_q[dcc_pkg::CB_EN];
						first_q[c] <= wdata_q[dcc_pkg::CB_EN];
						unit8_q[c] <= wdata_q[dcc_pkg::CB_UNIT8];
						sinc_q[c] <= wdata_q[dcc_pkg::CB_SINC];
						// Source wins when both directions are asked to increment
						dinc_q[c] <= wdata_q[dcc_pkg::CB_DINC] & ~wdata_q[dcc_pkg::CB_SINC];
						single_q[c] <= wdata_q[dcc_pkg::CB_SINGLE];
						if (!wdata_q[dcc_pkg::CB_REQ]) begin
							req_q[c] <= 1'b0;
						end
					end
					if (wstrb_q[1]) begin
						sel_q[c] <= wdata_q[dcc_pkg::CB_SEL_LO +: dcc_pkg::SEL_W];
					end
				end
				if (wr_do && awaddr_q == ch_base[c] + dcc_pkg::OFS_SRC && (sinc_q[c] || !en_q[c])) begin
					src_q[c] <= (src_q[c] & ~wmask[AW-1:0]) | (wdata_q[AW-1:0] & wmask[AW-1:0]);
				end
				if (wr_do && awaddr_q == ch_base[c] + dcc_pkg::OFS_DST && (dinc_q[c] || !en_q[c])) begin
					dst_q[c] <= (dst_q[c] & ~wmask[AW-1:0]) | (wdata_q[AW-1:0] & wmask[AW-1:0]);
				end
				if (wr_do && awaddr_q == ch_base[c] + dcc_pkg::OFS_RELOAD) begin
					rld_q[c] <= (rld_q[c] & ~wmask[CW-1:0]) | (wdata_q[CW-1:0] & wmask[CW-1:0]);
				end
				if (ev[c]) begin
					req_q[c] <= 1'b1;
				end
			end
		end
	end

	assign dma_irq = irq_q;

	// Arbitration and start of a unit
	always_comb begin
		go_ch = !(en_q[0] && req_q[0]);
		go = state_q == dcc_pkg::ST_IDLE && !need_cpu_q && |(en_q & req_q);
		go_src = src_q[go_ch];
		go_dst = dst_q[go_ch];
		if (sinc_q[go_ch] && !first_q[go_ch]) begin
			go_src = wptr_q[go_ch];
		end
		if (dinc_q[go_ch] && !first_q[go_ch]) begin
			go_dst = wptr_q[go_ch];
		end
	end

	assign done = state_q == dcc_pkg::ST_WRITE && clk_q == wr_len_q - 2'h1 && (part_q || !wr_two_q);

	// CPU gets one bus access after every unit
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			need_cpu_q <= 1'b0;
		end else if (done) begin
			need_cpu_q <= 1'b1;
		end else if (cpu_access_done) begin
			need_cpu_q <= 1'b0;
		end
	end

	// Read then write bus cycles of one unit
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= dcc_pkg::ST_IDLE;
			ch_q <= 1'b0;
			addr_q <= dcc_pkg::PTR_RESET;
			dst_a_q <= dcc_pkg::PTR_RESET;
			part_q <= 1'b0;
			rd_two_q <= 1'b0;
			wr_two_q <= 1'b0;
			clk_q <= 2'h0;
			rd_len_q <= dcc_pkg::J_FAST;
			wr_len_q <= dcc_pkg::J_FAST;
			data_q <= 16'h0000;
		end else begin
			unique case (state_q)
				dcc_pkg::ST_IDLE: begin
					if (go) begin
						state_q <= dcc_pkg::ST_READ;
						ch_q <= go_ch;
						addr_q <= go_src;
						dst_a_q <= go_dst;
						part_q <= 1'b0;
						clk_q <= 2'h0;
						rd_two_q <= two_parts(go_src, unit8_q[go_ch], bus8);
						wr_two_q <= two_parts(go_dst, unit8_q[go_ch], bus8);
						rd_len_q <= cyc_len(go_src, cfg_q);
						wr_len_q <= cyc_len(go_dst, cfg_q);
					end
				end
				dcc_pkg::ST_READ: begin
					if (clk_q != rd_len_q - 2'h1) begin
						clk_q <= clk_q + 2'h1;
					end else begin
						clk_q <= 2'h0;
						if (!rd_two_q) begin
							data_q <= unit8_q[ch_q] ? {8'h00, mem_rdata[7:0]} : mem_rdata;
						end else if (!part_q) begin
							data_q[7:0] <= mem_rdata[7:0];
						end else begin
							data_q[15:8] <= mem_rdata[7:0];
						end
						if (rd_two_q && !part_q) begin
							part_q <= 1'b1;
							addr_q <= addr_q + 20'h00001;
						end else begin
							state_q <= dcc_pkg::ST_WRITE;
							part_q <= 1'b0;
							addr_q <= dst_a_q;
						end
					end
				end
				dcc_pkg::ST_WRITE: begin
					if (clk_q != wr_len_q - 2'h1) begin
						clk_q <= clk_q + 2'h1;
					end else begin
						clk_q <= 2'h0;
						if (wr_two_q && !part_q) begin
							part_q <= 1'b1;
							addr_q <= addr_q + 20'h00001;
						end else begin
							state_q <= dcc_pkg::ST_IDLE;
							part_q <= 1'b0;
						end
					end
				end
			endcase
		end
	end

	// Memory side drive
	assign bus_hold = state_q != dcc_pkg::ST_IDLE;
	assign mem_valid = state_q != dcc_pkg::ST_IDLE;
	assign mem_write = state_q == dcc_pkg::ST_WRITE;
	assign mem_addr = addr_q;
	assign mem_byte = state_q == dcc_pkg::ST_WRITE ? (unit8_q[ch_q] || wr_two_q)
		: (unit8_q[ch_q] || rd_two_q);
	// Split words go low byte first, each half on the low lane
	assign mem_wdata = (wr_two_q && part_q) ? {8'h00, data_q[15:8]}
		: (wr_two_q ? {8'h00, data_q[7:0]} : data_q);
endmodule
`default_nettype wire

// *** dcc_checker.sv ***
// Port-level assertions for the transfer controller.
// Assumes it is bound into every dcc_dma instance.
`timescale 1ns/1ns
`default_nettype none
module dcc_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic expansion_mode,
	input wire logic bus_width_select,
	input wire logic cpu_access_done,
	input wire logic bus_hold,
	input wire logic mem_valid,
	input wire logic mem_write,
	input wire logic mem_byte,
	input wire logic [1:0] dma_irq
);
	logic owed_q;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// CPU access owed from each release until the CPU reports one
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			owed_q <= 1'h0;
		end else if ($fell(bus_hold)) begin
			owed_q <= 1'h1;
		end else if (cpu_access_done) begin
			owed_q <= 1'h0;
		end
	end
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("new write taken before response");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("new read taken before response");
	read_first_a: assert property ($rose(mem_valid) |-> !mem_write)
		else $error("unit began with a write");
	no_read_back_a: assert property (mem_valid && mem_write |=> !mem_valid || mem_write)
		else $error("read after write in one unit");
	unit_len_a: assert property ($rose(mem_valid) |-> ##[1:12] !mem_valid)
		else $error("unit longer than twelve clocks");
	byte_bus_a: assert property (mem_valid && expansion_mode && bus_width_select |-> mem_byte)
		else $error("word access on byte bus");
	cpu_between_a: assert property ($rose(bus_hold) |-> !owed_q)
		else $error("unit started with CPU access owed");
	irq_pulse_a: assert property (dma_irq[0] |=> !dma_irq[0])
		else $error("interrupt pulse longer than one clock");
	cover property ($rose(bus_hold));
	cover property (dma_irq[1]);
	cover property (mem_valid && mem_byte);
endmodule
bind dcc_dma dcc_checker u_chk (.aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .expansion_mode,
	.bus_width_select, .cpu_access_done, .bus_hold, .mem_valid, .mem_write, .mem_byte, .dma_irq);
`default_nettype wire

// *** dcc_far_model.sv ***
// Far side of the transfer controller: memory and the CPU.
// Assumes one clock shared with the controller.
`timescale 1ns/1ns
`default_nettype none
module dcc_far_model #(
	parameter int CPU_GAP = 3
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic bus_hold,
	input wire logic mem_valid,
	input wire logic mem_write,
	input wire logic [19:0] mem_addr,
	output logic [15:0] mem_rdata,
	output logic cpu_access_done
);
	int gap_q;
	logic tog_q;
	logic done_q;
	// Off-cycle data churns so a stale sample shows up
	assign mem_rdata = (mem_valid && !mem_write) ? ~mem_addr[15:0] : {8{tog_q, ~tog_q}};
	// No CPU access can finish while the bus is held
	assign cpu_access_done = done_q && !bus_hold;
	always_ff @(posedge aclk) begin
		tog_q <= aresetn ? !tog_q : 1'h0;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn || bus_hold) begin
			gap_q <= 0;
			done_q <= 1'h0;
		end else begin
			gap_q <= (gap_q == CPU_GAP) ? 0 : gap_q + 1;
			done_q <= (gap_q == CPU_GAP);
		end
	end
endmodule
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the transfer controller.
// Assumes the far model answers memory cycles and CPU accesses.
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, periph_irq = 8'h00;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
	logic s_axi_rready = 1'h0, expansion_mode = 1'h0, bus_width_select = 1'h0, cpu_access_done;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] external_interrupt_pin = 2'h3, s_axi_bresp, s_axi_rresp, dma_irq, bresp_l, rresp_l;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic bus_hold, mem_valid, mem_write, mem_byte, last_v = 1'h0;
	logic [19:0] mem_addr;
	logic [15:0] mem_wdata, mem_rdata, wd_l;
	logic [19:0] unit_q[$];
	int n_fail = 0, n_compared = 0, rd_clk, wr_clk;
	always #25 aclk = ~aclk;
	dcc_dma DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.expansion_mode, .bus_width_select, .external_interrupt_pin, .periph_irq, .cpu_access_done,
		.bus_hold, .mem_valid, .mem_write, .mem_byte, .mem_addr, .mem_wdata, .mem_rdata, .dma_irq);
	dcc_far_model far (.aclk, .aresetn, .bus_hold, .mem_valid, .mem_write, .mem_addr, .mem_rdata,
		.cpu_access_done);
	// Clocks per side and the start address of each unit
	always @(posedge aclk) begin
		if (mem_valid === 1'h1 && mem_write === 1'h0) rd_clk++;
		if (mem_valid === 1'h1 && mem_write === 1'h1) wr_clk++;
		if (mem_valid === 1'h1 && mem_write === 1'h1) wd_l = mem_wdata;
		if (mem_valid === 1'h1 && last_v !== 1'h1) unit_q.push_back(mem_addr);
		last_v = mem_valid;
	end
	task print_verdict;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task timeout;
		n_fail++;
		$display("BAD %0t wait ran out", $time);
		print_verdict();
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	function logic [31:0] ctl(input logic [3:0] sel, input logic [6:0] b);
		return {20'h0, sel, 1'h0, b};
	endfunction
	task axi_wr(input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'h1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (i = 0; i < 64; i++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid === 1'h1) break;
		end
		s_axi_bready <= 1'h0;
		bresp_l = s_axi_bresp;
		if (i == 64) timeout();
	endtask
	task axi_rd(input logic [7:0] a, output logic [31:0] d);
		int i;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (i = 0; i < 64; i++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid === 1'h1) break;
		end
		s_axi_rready <= 1'h0;
		d = s_axi_rdata;
		rresp_l = s_axi_rresp;
		if (i == 64) timeout();
	endtask
	task wait_irq(input int c);
		int i;
		for (i = 0; i < 200; i++) begin
			@(posedge aclk);
			if (dma_irq[c] === 1'h1) break;
		end
		if (i == 200) timeout();
	endtask
	task wait_units(input int n);
		int i;
		for (i = 0; i < 200; i++) begin
			@(posedge aclk);
			if (unit_q.size() >= n && bus_hold === 1'h0) break;
		end
		if (i == 200) timeout();
	endtask
	task run_unit(input logic [19:0] s, d, input logic u8, input logic [2:0] cfg, input logic ex, bw,
		input int er, ew);
		expansion_mode <= ex;
		bus_width_select <= bw;
		axi_wr(dcc_pkg::OFS_CFG, {29'h0, cfg});
		axi_wr(dcc_pkg::OFS_SRC, {12'h0, s});
		axi_wr(dcc_pkg::OFS_DST, {12'h0, d});
		axi_wr(dcc_pkg::OFS_RELOAD, 32'h0);
		rd_clk = 0;
		wr_clk = 0;
		unit_q.delete();
		axi_wr(dcc_pkg::OFS_CTRL, ctl(dcc_pkg::SEL_SOFT, {5'h15, u8, 1'h1}));
		wait_irq(0);
		axi_rd(dcc_pkg::OFS_CTRL, rd);
		chk(rd & 32'h1, 32'h0);
		chk(rd_clk, er);
		chk(wr_clk, ew);
		chk({12'h0, unit_q[0]}, {12'h0, s});
		if (er == 1 && ew == 1) chk({16'h0, wd_l}, u8 ? {24'h0, ~s[7:0]} : {16'h0, ~s[15:0]});
	endtask
	task t_reset;
		axi_rd(dcc_pkg::OFS_COUNT, rd);
		chk(rd, 32'h0);
		axi_rd(8'h3c, rd);
		chk({30'h0, rresp_l}, {30'h0, dcc_pkg::RESP_SLVERR});
		axi_wr(8'h3c, 32'h1);
		chk({30'h0, bresp_l}, {30'h0, dcc_pkg::RESP_SLVERR});
	endtask
	task t_cycles;
		run_unit(20'h01000, 20'h01100, 1'h0, 3'h0, 1'h0, 1'h0, 1, 1);
		run_unit(20'h01001, 20'h01101, 1'h0, 3'h0, 1'h0, 1'h0, 2, 2);
		run_unit(20'h01001, 20'h01100, 1'h0, 3'h0, 1'h0, 1'h0, 2, 1);
		run_unit(20'h01001, 20'h01101, 1'h1, 3'h0, 1'h0, 1'h0, 1, 1);
		run_unit(20'h01000, 20'h01100, 1'h0, 3'h0, 1'h1, 1'h1, 2, 2);
		run_unit(20'h01000, 20'h01100, 1'h0, 3'h0, 1'h0, 1'h1, 1, 1);
		run_unit(20'h00200, 20'h01100, 1'h0, 3'h0, 1'h0, 1'h0, 2, 1);
		run_unit(20'h01000, 20'h01100, 1'h0, 3'h1, 1'h0, 1'h0, 2, 2);
		run_unit(20'h10000, 20'h01100, 1'h0, 3'h4, 1'h0, 1'h0, 3, 1);
		run_unit(20'h10000, 20'h01100, 1'h0, 3'h2, 1'h0, 1'h0, 2, 1);
	endtask
	task t_flags;
		for (int i = 0; i < 4; i++) axi_wr(i[0] ? dcc_pkg::CH_STRIDE : 8'h00, ctl(dcc_pkg::SEL_EXT_FALL, 7'h0));
		external_interrupt_pin <= 2'h0;
		axi_rd(dcc_pkg::OFS_CTRL, rd);
		chk(rd & 32'h20, 32'h20);
		axi_rd(dcc_pkg::CH_STRIDE, rd);
		chk(rd & 32'h20, 32'h20);
		external_interrupt_pin <= 2'h3;
		axi_wr(dcc_pkg::OFS_CTRL, ctl(dcc_pkg::SEL_EXT_FALL, 7'h20));
		axi_rd(dcc_pkg::OFS_CTRL, rd);
		chk(rd & 32'h20, 32'h20);
		axi_wr(dcc_pkg::OFS_CTRL, ctl(dcc_pkg::SEL_EXT_FALL, 7'h0));
		axi_rd(dcc_pkg::OFS_CTRL, rd);
		chk(rd & 32'h20, 32'h0);
		for (int i = 0; i < 2; i++) axi_wr(dcc_pkg::OFS_CTRL, ctl(dcc_pkg::SEL_EXT_BOTH, 7'h0));
		external_interrupt_pin <= 2'h2;
		axi_wr(dcc_pkg::OFS_CTRL, ctl(dcc_pkg::SEL_EXT_BOTH, 7'h0));
		external_interrupt_pin <= 2'h3;
		axi_rd(dcc_pkg::OFS_CTRL, rd);
		chk(rd & 32'h20, 32'h20);
		for (int i = 0; i < 2; i++) axi_wr(dcc_pkg::CH_STRIDE, ctl(dcc_pkg::SEL_PERIPH0 + 4'h2, 7'h0));
		periph_irq <= 8'h04;
		@(posedge aclk);
		periph_irq <= 8'h00;
		axi_rd(dcc_pkg::CH_STRIDE, rd);
		chk(rd & 32'h20, 32'h20);
	endtask
	task t_prio;
		logic [7:0] o;
		for (int i = 0; i < 2; i++) begin
			o = i[0] ? dcc_pkg::CH_STRIDE : 8'h00;
			axi_wr(o, ctl(dcc_pkg::SEL_EXT_FALL, 7'h0));
			axi_wr(o + dcc_pkg::OFS_SRC, 32'h1000 << i);
			axi_wr(o + dcc_pkg::OFS_DST, 32'h1100 << i);
			axi_wr(o + dcc_pkg::OFS_RELOAD, 32'h0);
			axi_wr(o, ctl(dcc_pkg::SEL_EXT_FALL, 7'h15));
		end
		unit_q.delete();
		external_interrupt_pin <= 2'h0;
		wait_irq(1);
		external_interrupt_pin <= 2'h3;
		chk({12'h0, unit_q[0]}, 32'h1000);
		chk({12'h0, unit_q[1]}, 32'h2000);
		axi_rd(dcc_pkg::OFS_CTRL, rd);
		chk(rd & 32'h21, 32'h0);
	endtask
	task t_restart;
		axi_wr(dcc_pkg::OFS_CTRL, ctl(dcc_pkg::SEL_SOFT, 7'h0c));
		axi_rd(dcc_pkg::OFS_CTRL, rd);
		chk(rd & 32'hc, 32'h4);
		axi_wr(dcc_pkg::OFS_SRC, 32'h1000);
		axi_wr(dcc_pkg::OFS_DST, 32'h1100);
		axi_wr(dcc_pkg::OFS_RELOAD, 32'h2);
		unit_q.delete();
		axi_wr(dcc_pkg::OFS_CTRL, ctl(dcc_pkg::SEL_SOFT, 7'h55));
		wait_units(1);
		axi_rd(dcc_pkg::OFS_COUNT, rd);
		chk(rd, 32'h1);
		axi_wr(dcc_pkg::OFS_DST, 32'h1200);
		axi_rd(dcc_pkg::OFS_DST, rd);
		chk(rd, 32'h1100);
		axi_wr(dcc_pkg::OFS_CTRL, ctl(dcc_pkg::SEL_SOFT, 7'h55));
		wait_units(2);
		chk({12'h0, unit_q[1]}, 32'h1000);
		axi_rd(dcc_pkg::OFS_COUNT, rd);
		chk(rd, 32'h1);
	endtask
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		t_reset();
		t_cycles();
		t_flags();
		t_prio();
		t_restart();
		print_verdict();
	end
endmodule
`default_nettype wire
